// ===== design/bsrp_pkg.sv
// shared constants and carrier types for the burst sram read port
package bsrp_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int DATA_W = 18;
  localparam int LANE_W = 9;
  localparam int LANES = DATA_W / LANE_W;
  localparam int ADDR_W = 8;
  localparam int BURST_LEN = 2;

  // ---------------------------------------------------------------
  // timing figures
  // ---------------------------------------------------------------
  localparam int CORE_CLK_MHZ = 50;
  localparam int LEGACY_MAX_MHZ = 167;
  localparam int SYNC_STAGES = 2;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic k;
    logic k_n;
    logic pll_off_n;
    logic load_strobe_n;
    logic read_not_write;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] byte_write_mask_n;
    logic [DATA_W-1:0] dq;
  } bsrp_pins_t;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
  } bsrp_rd_slot_t;

  typedef struct packed {
    logic [DATA_W-1:0] w0;
    logic [DATA_W-1:0] w1;
  } bsrp_burst_t;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
  } bsrp_half_slot_t;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam bsrp_pins_t PINS_RST = '{
    k: 1'b0, k_n: 1'b0, pll_off_n: 1'b1, load_strobe_n: 1'b1, read_not_write: 1'b1,
    addr: '0, byte_write_mask_n: '1, dq: '0
  };
  localparam bsrp_rd_slot_t RD_SLOT_RST = '{valid: 1'b0, addr: '0};
  localparam bsrp_half_slot_t HALF_SLOT_RST = '{valid: 1'b0, data: '0};
  localparam bsrp_burst_t BURST_RST = '{w0: '0, w1: '0};

endpackage

// ===== design/bsrp_pair_buffer.sv
// small valid/ready buffer that holds fetched read bursts
`timescale 1ns/100ps
`default_nettype none

module bsrp_pair_buffer #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 2
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] FULL = CNT_W'(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] count;
  logic push;
  logic pop;

  assign in_ready_o = (count != FULL);
  assign out_valid_o = (count != '0);
  assign out_data_o = store[rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge core_clk_i) begin
    if (push) begin
      store[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      count <= '0;
    end else if (push && !pop) begin
      count <= count + 1'b1;
    end else if (pop && !push) begin
      count <= count - 1'b1;
    end
  end

endmodule // bsrp_pair_buffer

`default_nettype wire

// ===== design/bsrp_read_port.sv
// device-side logic of a two-word burst ddr sram: command capture, array, read launch
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// R1: echo clocks run freely, following the positive input clock, never gated.
// R2: low pll_off_n selects legacy mode; controller keeps clock at or below 167 MHz.
// R3: pll_off_n high gives read latency of two and a half clock cycles.
// R4: pll_off_n low gives read latency of one clock cycle.
// R5: accesses start only on a positive input clock rising edge.
// R6: incoming data words are registered on rises of both input clocks.
// R7: outgoing words launch from registers on rises of both input clocks.
// R8: direction, load strobe and byte masks are captured on positive clock rises.
// R9: every access moves two consecutive words for one address.
// R10: direction high with load strobe low starts a read, address stored.
// R11: first word after two further positive rises, second word on next edge.
// R12: controller never aborts or truncates a read burst.
// R13: reads may be issued on every positive rise, accepted back to back.
// R14: deselected reads still finish every burst already in the pipeline.
// R15: after draining, outputs float following the next negative clock rise.
// R16: controller drops load strobe only when it defines a new command.
// R17: extended mode: word A at negative rise t+2, A+1 at positive rise t+3.
// R18: output_valid rises half a cycle before data, aligned with echo clocks; in legacy mode the code raises it with the first word.
module bsrp_read_port #(
  parameter int MEM_WORDS = 256,
  parameter int BUF_DEPTH = 2
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic k_i,
  input wire logic k_n_i,
  input wire logic pll_off_n_i,
  input wire logic load_strobe_n_i,
  input wire logic read_not_write_i,
  input wire logic [bsrp_pkg::ADDR_W-1:0] addr_i,
  input wire logic [bsrp_pkg::LANES-1:0] byte_write_mask_n_i,
  input wire logic [bsrp_pkg::DATA_W-1:0] dq_i,
  output logic [bsrp_pkg::DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  output logic echo_clock_pos_o,
  output logic echo_clock_neg_o,
  output logic output_valid_o
);

  // ---------------------------------------------------------------
  // pin synchroniser and edge finders
  // ---------------------------------------------------------------
  bsrp_pkg::bsrp_pins_t pins_raw;
  bsrp_pkg::bsrp_pins_t pins_meta;
  bsrp_pkg::bsrp_pins_t pins;
  logic k_prev;
  logic k_n_prev;
  logic k_rise;
  logic k_n_rise;
  logic k_rise_q;

  assign pins_raw = '{
    k: k_i,
    k_n: k_n_i,
    pll_off_n: pll_off_n_i,
    load_strobe_n: load_strobe_n_i,
    read_not_write: read_not_write_i,
    addr: addr_i,
    byte_write_mask_n: byte_write_mask_n_i,
    dq: dq_i
  };

  // every pin, the two input clocks included, crosses in the same two stages,
  // so controls and data stay aligned with the clock edges that carry them;
  // the price is a lag of two core cycles on every input and three on each echo
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pins_meta <= bsrp_pkg::PINS_RST;
      pins <= bsrp_pkg::PINS_RST;
    end else begin
      pins_meta <= pins_raw;
      pins <= pins_meta;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      k_prev <= 1'b0;
      k_n_prev <= 1'b0;
      k_rise_q <= 1'b0;
    end else begin
      k_prev <= pins.k;
      k_n_prev <= pins.k_n;
      k_rise_q <= k_rise;
    end
  end

  assign k_rise = pins.k && !k_prev; // [R5]
  assign k_n_rise = pins.k_n && !k_n_prev;

  // ---------------------------------------------------------------
  // echo clocks
  // ---------------------------------------------------------------
  // no term of read or write activity enters here: the echoes keep running
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      echo_clock_pos_o <= 1'b0;
      echo_clock_neg_o <= 1'b0;
    end else begin
      echo_clock_pos_o <= pins.k; // [R1]
      echo_clock_neg_o <= pins.k_n; // [R1]
    end
  end

  // ---------------------------------------------------------------
  // latency mode
  // ---------------------------------------------------------------
  logic legacy_mode;
  logic reads_idle;

  // taken on a positive rise only while no read is in flight: a burst fetched
  // under one latency and launched under the other would be lost or sent twice;
  // a pin change therefore waits while the controller streams reads
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      legacy_mode <= 1'b0;
    end else if (k_rise && reads_idle) begin
      legacy_mode <= !pins.pll_off_n; // [R2]
    end
  end

  // ---------------------------------------------------------------
  // command capture
  // ---------------------------------------------------------------
  logic rd_cmd;
  logic wr_cmd;
  bsrp_pkg::bsrp_rd_slot_t rd_stage1;
  bsrp_pkg::bsrp_rd_slot_t rd_stage2;

  // one decode serves both directions, so the no-op case lives in one place
  function automatic logic cmd_is(
    input bsrp_pkg::bsrp_pins_t p,
    input logic want_read
  );
    return !p.load_strobe_n && (p.read_not_write == want_read);
  endfunction

  // a high load strobe is a no-op, whatever the direction pin shows
  assign rd_cmd = cmd_is(pins, 1'b1); // [R10] [R16]
  assign wr_cmd = cmd_is(pins, 1'b0); // [R16]

  // a fresh read can enter on every positive rise; older ones move down
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rd_stage1 <= bsrp_pkg::RD_SLOT_RST;
      rd_stage2 <= bsrp_pkg::RD_SLOT_RST;
    end else if (k_rise) begin
      rd_stage1 <= '{valid: rd_cmd, addr: pins.addr}; // [R5] [R8] [R10] [R13]
      rd_stage2 <= rd_stage1; // [R14]
    end
  end

  // ---------------------------------------------------------------
  // write capture and array
  // ---------------------------------------------------------------
  logic [bsrp_pkg::DATA_W-1:0] mem_lo [MEM_WORDS];
  logic [bsrp_pkg::DATA_W-1:0] mem_hi [MEM_WORDS];
  logic wr_wait;
  logic [bsrp_pkg::ADDR_W-1:0] wr_addr;
  logic wr_half;
  logic [bsrp_pkg::ADDR_W-1:0] wr_half_addr;
  logic [bsrp_pkg::DATA_W-1:0] wr_word0;
  logic [bsrp_pkg::LANES-1:0] wr_mask0_n;

  // write address is taken at t, the first data word one positive rise later
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wr_wait <= 1'b0;
      wr_addr <= '0;
    end else if (k_rise) begin
      wr_wait <= wr_cmd; // [R8]
      wr_addr <= pins.addr;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wr_half <= 1'b0;
      wr_half_addr <= '0;
      wr_word0 <= '0;
      wr_mask0_n <= '1;
    end else if (k_rise) begin
      wr_half <= wr_wait;
      wr_half_addr <= wr_addr;
      wr_word0 <= pins.dq; // [R6]
      wr_mask0_n <= pins.byte_write_mask_n; // [R8]
    end else if (k_n_rise) begin
      wr_half <= 1'b0;
    end
  end

  // a lane whose mask bit is high keeps the byte already stored there
  function automatic logic [bsrp_pkg::DATA_W-1:0] lane_merge(
    input logic [bsrp_pkg::DATA_W-1:0] old_word,
    input logic [bsrp_pkg::DATA_W-1:0] new_word,
    input logic [bsrp_pkg::LANES-1:0] mask_n
  );
    logic [bsrp_pkg::DATA_W-1:0] merged;
    merged = old_word;
    for (int l = 0; l < bsrp_pkg::LANES; l++) begin
      if (!mask_n[l]) begin
        merged[l*bsrp_pkg::LANE_W +: bsrp_pkg::LANE_W] = new_word[l*bsrp_pkg::LANE_W +: bsrp_pkg::LANE_W];
      end
    end
    return merged;
  endfunction

  // second word lands on the negative rise; both words commit together.
  // no bypass: a legacy read right behind a write to the same address sees the old words
  always_ff @(posedge core_clk_i) begin
    if (k_n_rise && wr_half) begin
      mem_lo[wr_half_addr] <= lane_merge(mem_lo[wr_half_addr], wr_word0, wr_mask0_n); // [R6] [R9]
      mem_hi[wr_half_addr] <= lane_merge(mem_hi[wr_half_addr], pins.dq, pins.byte_write_mask_n); // [R6] [R9]
    end
  end

  // ---------------------------------------------------------------
  // burst fetch
  // ---------------------------------------------------------------
  bsrp_pkg::bsrp_rd_slot_t due;
  logic fetch_valid;
  bsrp_pkg::bsrp_burst_t fetch_burst;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_pop;
  bsrp_pkg::bsrp_burst_t buf_burst;

  // legacy reads are due on the command's own positive rise, extended ones one positive rise later
  assign due = legacy_mode ? rd_stage1 : rd_stage2; // [R3] [R4]

  // the fetch register holds until the buffer takes it, and refuses new work
  // meanwhile; pops happen every positive rise, so it never really has to wait
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      fetch_valid <= 1'b0;
      fetch_burst <= bsrp_pkg::BURST_RST;
    end else if (k_rise_q && due.valid && (!fetch_valid || buf_in_ready)) begin
      fetch_valid <= 1'b1;
      fetch_burst <= '{w0: mem_lo[due.addr], w1: mem_hi[due.addr]}; // [R9]
    end else if (buf_in_ready) begin
      fetch_valid <= 1'b0;
    end
  end

  // two entries let a fetched burst wait while the launcher still sends the one before
  bsrp_pair_buffer #(
    .WIDTH($bits(bsrp_pkg::bsrp_burst_t)),
    .DEPTH(BUF_DEPTH)
  ) u_burst_buf (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .in_valid_i(fetch_valid),
    .in_ready_o(buf_in_ready),
    .in_data_i(fetch_burst),
    .out_valid_o(buf_out_valid),
    .out_ready_i(buf_pop),
    .out_data_o(buf_burst)
  );

  // launcher only takes a burst on a positive rise,
  // so an extended burst always starts on the negative rise that follows
  assign buf_pop = k_rise && buf_out_valid; // [R5] [R13]

  // ---------------------------------------------------------------
  // output launcher
  // ---------------------------------------------------------------
  bsrp_pkg::bsrp_half_slot_t slot_a;
  bsrp_pkg::bsrp_half_slot_t slot_b;
  bsrp_pkg::bsrp_half_slot_t next_slot_a;
  bsrp_pkg::bsrp_half_slot_t next_slot_b;
  logic [bsrp_pkg::DATA_W-1:0] next_dq;
  logic next_oe;

  // nothing waits in the command stages, the fetch register, the buffer or the slots
  assign reads_idle = !rd_stage1.valid && !rd_stage2.valid && !fetch_valid && !buf_out_valid &&
    !slot_a.valid && !slot_b.valid;

  // slot_a holds the word for the next input clock rise, slot_b the one after;
  // a legacy burst skips the slots for its first word, sent on the popping rise
  always_comb begin
    next_slot_a = slot_a;
    next_slot_b = slot_b;
    next_dq = dq_o;
    next_oe = dq_oe_o;
    if (k_rise || k_n_rise) begin
      next_dq = slot_a.data; // [R7]
      next_oe = slot_a.valid; // [R14] [R15]
      next_slot_a = slot_b;
      next_slot_b = bsrp_pkg::HALF_SLOT_RST;
      if (buf_pop) begin
        if (legacy_mode) begin
          next_dq = buf_burst.w0; // [R4] [R7]
          next_oe = 1'b1;
          next_slot_a = '{valid: 1'b1, data: buf_burst.w1}; // [R9]
          next_slot_b = bsrp_pkg::HALF_SLOT_RST;
        end else begin
          next_slot_a = '{valid: 1'b1, data: buf_burst.w0}; // [R3] [R11] [R17]
          next_slot_b = '{valid: 1'b1, data: buf_burst.w1}; // [R9] [R11] [R17]
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      slot_a <= bsrp_pkg::HALF_SLOT_RST;
      slot_b <= bsrp_pkg::HALF_SLOT_RST;
    end else begin
      slot_a <= next_slot_a;
      slot_b <= next_slot_b;
    end
  end

  // the drivers float once no slot is left, on the rise that follows the last
  // word, so a neighbouring bank may take the bus with no wait state
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      dq_o <= '0;
      dq_oe_o <= 1'b0;
    end else begin
      dq_o <= next_dq; // [R7]
      dq_oe_o <= next_oe; // [R15]
    end
  end

  // valid tracks the word due at the next input clock rise, hence half a cycle early;
  // legacy bursts give no such warning: valid rises with their first word
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      output_valid_o <= 1'b0;
    end else begin
      output_valid_o <= next_slot_a.valid; // [R18]
    end
  end

endmodule // bsrp_read_port

`default_nettype wire

// ===== dv/bsrp_read_port_properties.sv
// concurrent checks on the pins of the burst sram read port
`timescale 1ns/100ps
`default_nettype none
module bsrp_read_port_properties (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic k_i,
  input wire logic k_n_i,
  input wire logic pll_off_n_i,
  input wire logic load_strobe_n_i,
  input wire logic [bsrp_pkg::DATA_W-1:0] dq_o,
  input wire logic dq_oe_o,
  input wire logic echo_clock_pos_o,
  input wire logic echo_clock_neg_o,
  input wire logic output_valid_o
);
  // ---------------------------------------------------------------
  // helper counters
  // ---------------------------------------------------------------
  logic [7:0] since_rst;
  logic [7:0] idle_cnt;
  // echoes need the synchronisers flushed before they can be compared
  always_ff @(posedge core_clk_i) begin
    if (rst_i) since_rst <= 8'h00;
    else if (since_rst != 8'hff) since_rst <= since_rst + 8'h01;
  end
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !load_strobe_n_i) idle_cnt <= 8'h00;
    else if (idle_cnt != 8'hff) idle_cnt <= idle_cnt + 8'h01;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_echo_pos_track: assert property (since_rst > 8'h04 |-> echo_clock_pos_o == $past(k_i, 3))
    else $error("echo_clock_pos_o does not follow k_i");
  a_echo_neg_track: assert property (since_rst > 8'h04 |-> echo_clock_neg_o == $past(k_n_i, 3))
    else $error("echo_clock_neg_o does not follow k_n_i");
  a_valid_lead: assert property ($rose(dq_oe_o) && pll_off_n_i |-> $past(output_valid_o, 4))
    else $error("output_valid_o not high half a cycle before data");
  a_valid_with_data: assert property ($rose(dq_oe_o) |-> output_valid_o)
    else $error("output_valid_o low at first data word");
  a_burst_two_words: assert property ($rose(dq_oe_o) |-> dq_oe_o [*8])
    else $error("data enable shorter than a two word burst");
  a_data_holds: assert property (!$stable(dq_o) |=> $stable(dq_o) [*3])
    else $error("dq_o changed between link clock edges");
  a_valid_holds: assert property (!$stable(output_valid_o) |=> $stable(output_valid_o) [*3])
    else $error("output_valid_o changed between link clock edges");
  a_idle_quiet: assert property (idle_cnt > 8'h28 |-> !dq_oe_o && !output_valid_o)
    else $error("outputs active long after the last command");
endmodule // bsrp_read_port_properties

bind bsrp_read_port bsrp_read_port_properties bsrp_read_port_properties_inst (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .k_i(k_i), .k_n_i(k_n_i), .pll_off_n_i(pll_off_n_i),
  .load_strobe_n_i(load_strobe_n_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .echo_clock_pos_o(echo_clock_pos_o),
  .echo_clock_neg_o(echo_clock_neg_o), .output_valid_o(output_valid_o));
`default_nettype wire

// ===== dv/bsrp_ctrl_model.sv
// partner model of the memory controller: link clocks, commands, write data
`timescale 1ns/100ps
`default_nettype none
module bsrp_ctrl_model (
  output logic k_o,
  output logic k_n_o,
  output logic load_strobe_n_o,
  output logic read_not_write_o,
  output logic [bsrp_pkg::ADDR_W-1:0] addr_o,
  output logic [bsrp_pkg::LANES-1:0] byte_write_mask_n_o,
  output logic [bsrp_pkg::DATA_W-1:0] dq_o,
  output int edge_no_o
);
  // link clock runs freely at 6.25 MHz, far under the legacy ceiling
  initial begin
    {k_o, k_n_o, load_strobe_n_o, read_not_write_o} = 4'h7;
    addr_o = '0;
    byte_write_mask_n_o = '1;
    dq_o = '0;
    edge_no_o = 0;
    #7;
    forever begin
      edge_no_o = edge_no_o + 1;
      k_o = ~k_o;
      k_n_o = ~k_o;
      #80;
    end
  end
  // pins move a core cycle ahead of a link edge so they stand across it
  task automatic issue(input logic rnw, input logic [bsrp_pkg::ADDR_W-1:0] a, output int t);
    @(negedge k_o);
    t = edge_no_o + 1;
    #60;
    load_strobe_n_o = 1'b0; // strobe low only with a full command, taken at k rise
    read_not_write_o = rnw;
    addr_o = a;
  endtask
  task automatic nop();
    @(negedge k_o);
    #60;
    load_strobe_n_o = 1'b1;
    read_not_write_o = ~read_not_write_o;
    addr_o = ~addr_o;
  endtask
  // no abort path exists, so every read burst runs out
  task automatic write(input logic [bsrp_pkg::ADDR_W-1:0] a, input logic [bsrp_pkg::DATA_W-1:0] w0, w1,
      input logic [bsrp_pkg::LANES-1:0] m0, m1);
    int t;
    issue(1'b0, a, t);
    nop();
    dq_o = w0;
    byte_write_mask_n_o = m0;
    @(posedge k_o);
    #60;
    dq_o = w1;
    byte_write_mask_n_o = m1;
    @(negedge k_o);
    #60;
    dq_o = ~w1; // released lines show no stale word
    byte_write_mask_n_o = ~m1;
  endtask
endmodule // bsrp_ctrl_model
`default_nettype wire

// ===== dv/tb_top.sv
// self-checking bench for the burst sram read port
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic pll_off_n_i = 1'b1;
  logic k, k_n, ld_n, rnw, dq_oe, echo_p, echo_n, out_vld;
  logic [7:0] addr;
  logic [1:0] mask_n;
  logic [17:0] dq_in, dq_out;
  int edge_no;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [21:0] hist [0:1023];
  logic [17:0] mem_lo [0:255];
  logic [17:0] mem_hi [0:255];
  always #10 core_clk_i = ~core_clk_i;
  bsrp_ctrl_model bsrp_ctrl_model_inst (.k_o(k), .k_n_o(k_n), .load_strobe_n_o(ld_n), .read_not_write_o(rnw),
    .addr_o(addr), .byte_write_mask_n_o(mask_n), .dq_o(dq_in), .edge_no_o(edge_no));
  bsrp_read_port bsrp_read_port_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .k_i(k), .k_n_i(k_n),
    .pll_off_n_i(pll_off_n_i), .load_strobe_n_i(ld_n), .read_not_write_i(rnw), .addr_i(addr),
    .byte_write_mask_n_i(mask_n), .dq_i(dq_in), .dq_o(dq_out), .dq_oe_o(dq_oe), .echo_clock_pos_o(echo_p),
    .echo_clock_neg_o(echo_n), .output_valid_o(out_vld));
  // each entry holds what the pins showed during the half cycle before that link edge
  always @(k) hist[edge_no % 1024] = {echo_p, echo_n, dq_oe, out_vld, dq_out};
  // ---------------------------------------------------------------
  // reporting
  // ---------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic check_word(input string what, input logic [17:0] exp, input logic [17:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_bit(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic wait_edge(input int n);
    while (edge_no < n) @(posedge core_clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [17:0] w0, w1, input logic [1:0] m0, m1);
    for (int l = 0; l < bsrp_pkg::LANES; l++) begin
      if (!m0[l]) mem_lo[a][l*bsrp_pkg::LANE_W +: bsrp_pkg::LANE_W] = w0[l*bsrp_pkg::LANE_W +: bsrp_pkg::LANE_W];
      if (!m1[l]) mem_hi[a][l*bsrp_pkg::LANE_W +: bsrp_pkg::LANE_W] = w1[l*bsrp_pkg::LANE_W +: bsrp_pkg::LANE_W];
    end
    bsrp_ctrl_model_inst.write(a, w0, w1, m0, m1);
  endtask
  task automatic rd(input logic [7:0] a, output int t);
    bsrp_ctrl_model_inst.issue(1'b1, a, t);
  endtask
  task automatic chk_read(input int t, input logic [7:0] a, input logic last);
    int d;
    int v;
    d = pll_off_n_i ? t + 6 : t + 3;
    v = pll_off_n_i ? d - 1 : d;
    wait_edge(d + 3);
    check_word("first word", mem_lo[a], hist[d % 1024][17:0]);
    check_word("second word", mem_hi[a], hist[(d + 1) % 1024][17:0]);
    check_bit("data enable", 1'b1, hist[(d + 1) % 1024][19]);
    check_bit("valid lead", 1'b1, hist[v % 1024][18]);
    if (last) check_bit("valid drop", 1'b0, hist[(d + 1) % 1024][18]);
    if (last) check_bit("float after drain", 1'b0, hist[(d + 2) % 1024][19]);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic sc_idle();
    int e;
    e = edge_no;
    repeat (6) bsrp_ctrl_model_inst.nop();
    wait_edge(e + 14);
    for (int i = e + 2; i < e + 14; i++) begin
      check_bit("echo pos", (i % 2 == 0), hist[i % 1024][21]);
      check_bit("echo neg", (i % 2 != 0), hist[i % 1024][20]);
      check_bit("nop enable", 1'b0, hist[i % 1024][19]);
    end
  endtask
  task automatic sc_ext_rw();
    int t;
    wr(8'h00, 18'h2a5c3, 18'h1b00f, 2'h0, 2'h0);
    wr(8'hff, 18'h3fffe, 18'h00001, 2'h0, 2'h0);
    rd(8'hff, t);
    bsrp_ctrl_model_inst.nop();
    chk_read(t, 8'hff, 1'b1);
  endtask
  task automatic sc_mask();
    int t;
    wr(8'h5a, 18'h3ffff, 18'h3ffff, 2'h0, 2'h0);
    wr(8'h5a, 18'h00000, 18'h00000, 2'h2, 2'h1);
    rd(8'h5a, t);
    bsrp_ctrl_model_inst.nop();
    chk_read(t, 8'h5a, 1'b1);
  endtask
  task automatic sc_b2b();
    int t0, t1, t2;
    rd(8'h00, t0);
    rd(8'hff, t1);
    rd(8'h5a, t2);
    bsrp_ctrl_model_inst.nop();
    chk_read(t0, 8'h00, 1'b0);
    chk_read(t1, 8'hff, 1'b0);
    chk_read(t2, 8'h5a, 1'b1);
  endtask
  task automatic sc_legacy();
    int t0, t1;
    @(posedge core_clk_i);
    pll_off_n_i <= 1'b0;
    wait_edge(edge_no + 2);
    rd(8'h5a, t0);
    rd(8'h00, t1);
    bsrp_ctrl_model_inst.nop();
    chk_read(t0, 8'h5a, 1'b0);
    chk_read(t1, 8'h00, 1'b1);
    @(posedge core_clk_i);
    pll_off_n_i <= 1'b1;
  endtask
  initial begin
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    sc_idle();
    sc_ext_rw();
    sc_mask();
    sc_b2b();
    sc_legacy();
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
